// ===== core/dgps_pkg.sv
// Shared constants and types for the diagnostic registered ROM with shadow scan
package dgps_pkg;

  // Array geometry defaults
  localparam int unsigned DEF_ADDR_W   = 12;
  localparam int unsigned DEF_WORD_W   = 4;
  localparam int unsigned DEF_ROM_WORDS = 4096;

  // Arbitrary fill seed for the built-in array contents (value is arbitrary)
  localparam logic [3:0]  DEF_ROM_SEED = 4'h5;

  // Depth of the capture observation buffer
  localparam int unsigned BUF_DEPTH    = 2;

  // Synchroniser stages on every pin input
  localparam int unsigned SYNC_STAGES  = 2;

  // Bit positions inside the synchronised pin vector
  localparam int unsigned PIN_MCLK     = 0;
  localparam int unsigned PIN_DIAG_CLOCK     = 1;
  localparam int unsigned PIN_MODE     = 2;
  localparam int unsigned PIN_SIN      = 3;
  localparam int unsigned PIN_OEN      = 4;
  localparam int unsigned PIN_ADDR_LSB = 5;

  // Reset values of the control flops
  localparam logic        RST_OEN      = 1'b1;
  localparam logic        RST_OE       = 1'b0;
  localparam logic        RST_SOUT     = 1'b0;
  localparam logic        RST_VALID    = 1'b0;

  // Shadow register operation for one cycle
  typedef enum {
    SH_IDLE,
    SH_SHIFT,
    SH_CAPTURE,
    SH_NOP
  } dgps_shop_e;

endpackage

// ===== core/dgps_rom.sv
// Read-only word array with registered read data
`timescale 1ns/1ps
module dgps_rom #(
  parameter int unsigned ADDR_W = dgps_pkg::DEF_ADDR_W,
  parameter int unsigned WORD_W = dgps_pkg::DEF_WORD_W,
  parameter logic [3:0]  SEED   = dgps_pkg::DEF_ROM_SEED
) (
  // Clock
  input  wire logic              clk_i,
  // Read port
  input  wire logic [ADDR_W-1:0] addr_i,
  output logic      [WORD_W-1:0] data_o
);
  import dgps_pkg::*;

  logic [WORD_W-1:0] data_q;
  logic [WORD_W-1:0] data_d;

  // Contents are a fixed fold of the address; a real part would hold a mask pattern
  function automatic logic [WORD_W-1:0] rom_word(input logic [ADDR_W-1:0] a);
    logic [WORD_W-1:0] acc;
    acc = WORD_W'(SEED);
    for (int i = 0; i < ADDR_W; i++) begin
      acc[i % WORD_W] = acc[i % WORD_W] ^ a[i];
    end
    return acc;
  endfunction

  // Next read word
  always_comb begin
    data_d = rom_word(addr_i);
  end

  // Read data register; no reset, data path only
  always_ff @(posedge clk_i) begin
    data_q <= data_d;
  end

  assign data_o = data_q;

endmodule

// ===== core/dgps_top.sv
// Registered read-only store with shadow scan register, sampled-pin implementation
`timescale 1ns/1ps

module dgps_top #(
  parameter int unsigned ADDR_W = dgps_pkg::DEF_ADDR_W,
  parameter int unsigned WORD_W = dgps_pkg::DEF_WORD_W
) (
  // System clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // Sequencer pins
  input  wire logic              main_clock_i,
  input  wire logic [ADDR_W-1:0] word_select_i,
  input  wire logic              mode_i,
  // Diagnostic scan pins
  input  wire logic              diag_clock_i,
  input  wire logic              serial_in_i,
  output logic                   serial_out_o,
  // Data bus pins
  input  wire logic              output_enable_n_i,
  input  wire logic [WORD_W-1:0] data_out_i,
  output logic      [WORD_W-1:0] data_out_o,
  output logic                   data_out_oe_o,
  // Capture observation stream
  output logic      [WORD_W-1:0] obs_data_o,
  output logic                   obs_valid_o,
  input  wire logic              obs_ready_i,
  output logic                   obs_room_o,
  output logic                   obs_drop_o
);
  import dgps_pkg::*;

  // Layout of the synchronised pin vector
  localparam int unsigned DIN_LSB = PIN_ADDR_LSB + ADDR_W;
  localparam int unsigned SV_W    = DIN_LSB + WORD_W;
  localparam logic [SV_W-1:0] SV_RST = SV_W'(RST_OEN) << PIN_OEN;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [SV_W-1:0]   pin_raw;
  logic [SV_W-1:0]   meta_q;
  logic [SV_W-1:0]   meta_d;
  logic [SV_W-1:0]   sync_q;
  logic [SV_W-1:0]   sync_d;
  logic              mclk_prev_q;
  logic              mclk_prev_d;
  logic              diag_clock_prev_q;
  logic              diag_clock_prev_d;

  // Every pin is asynchronous to clk_i, so all of them share one pipeline
  assign pin_raw = {data_out_i, word_select_i, output_enable_n_i,
                    serial_in_i, mode_i, diag_clock_i, main_clock_i};

  // Next values; the first stage feeds only the second
  always_comb begin
    meta_d      = pin_raw;
    sync_d      = meta_q;
    mclk_prev_d = sync_q[PIN_MCLK];
    diag_clock_prev_d = sync_q[PIN_DIAG_CLOCK];
  end

  // Reset puts the bus in its released state so no drive glitch appears
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      meta_q      <= SV_RST;
      sync_q      <= SV_RST;
      mclk_prev_q <= 1'b0;
      diag_clock_prev_q <= 1'b0;
    end else begin
      meta_q      <= meta_d;
      sync_q      <= sync_d;
      mclk_prev_q <= mclk_prev_d;
      diag_clock_prev_q <= diag_clock_prev_d;
    end
  end

  // Decoded synchronised levels and edges
  logic              mclk_rise;
  logic              diag_clock_rise;
  logic              mode_s;
  logic              sin_s;
  logic              oen_s;
  logic [ADDR_W-1:0] addr_s;
  logic [WORD_W-1:0] din_s;

  assign mclk_rise = sync_q[PIN_MCLK] & ~mclk_prev_q;
  assign diag_clock_rise = sync_q[PIN_DIAG_CLOCK] & ~diag_clock_prev_q;
  assign mode_s    = sync_q[PIN_MODE];
  assign sin_s     = sync_q[PIN_SIN];
  assign oen_s     = sync_q[PIN_OEN];
  assign addr_s    = sync_q[PIN_ADDR_LSB +: ADDR_W];
  assign din_s     = sync_q[DIN_LSB +: WORD_W];

  // ---------------------------------------------------------------
  // Array
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] rom_q;

  // Read address is the synchronised select; setup on the pins far exceeds one cycle
  dgps_rom #(
    .ADDR_W (ADDR_W),
    .WORD_W (WORD_W),
    .SEED   (DEF_ROM_SEED)
  ) u_rom (
    .clk_i  (clk_i),
    .addr_i (addr_s),
    .data_o (rom_q)
  );

  // ---------------------------------------------------------------
  // Output register
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] out_q;
  logic [WORD_W-1:0] out_d;
  logic [WORD_W-1:0] shadow_q;

  // Loads only on a main clock rise; the source follows the mode level
  always_comb begin
    out_d = out_q;
    if (mclk_rise) begin
      if (mode_s) begin
        out_d = shadow_q;
      end else begin
        out_d = rom_q;
      end
    end
  end

  // Deliberately without reset: the part powers up with an unknown word
  always_ff @(posedge clk_i) begin
    out_q <= out_d;
  end

  // ---------------------------------------------------------------
  // Output drivers
  // ---------------------------------------------------------------
  logic              oe_q;
  logic              oe_d;

  // Enable depends on the enable pin alone, never on either clock edge
  always_comb begin
    oe_d = ~oen_s;
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      oe_q <= RST_OE;
    end else begin
      oe_q <= oe_d;
    end
  end

  assign data_out_o    = out_q;
  assign data_out_oe_o = oe_q;

  // ---------------------------------------------------------------
  // Shadow register
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] shadow_d;
  logic [WORD_W-1:0] capture_src;
  dgps_shop_e        shop;

  // Classify what a diag_clock rise does under the current mode and serial_in
  function automatic dgps_shop_e shadow_op(input logic rise, input logic mode,
                                           input logic sin);
    dgps_shop_e op;
    op = SH_IDLE;
    if (rise) begin
      if (!mode) begin
        op = SH_SHIFT;
      end else if (!sin) begin
        op = SH_CAPTURE;
      end else begin
        op = SH_NOP;
      end
    end
    return op;
  endfunction

  assign shop = shadow_op(diag_clock_rise, mode_s, sin_s);

  // With drivers released the pins are inputs, so capture what others drive
  assign capture_src = oe_q ? out_q : din_s;

  // Capture sees the old output word even when both clocks rise together
  always_comb begin
    shadow_d = shadow_q;
    case (shop)
      SH_SHIFT: begin
        shadow_d = {shadow_q[WORD_W-2:0], sin_s};
      end
      SH_CAPTURE: begin
        shadow_d = capture_src;
      end
      SH_NOP: begin
        shadow_d = shadow_q;
      end
      SH_IDLE: begin
        shadow_d = shadow_q;
      end
      default: begin
        shadow_d = shadow_q;
      end
    endcase
  end

  // Deliberately without reset, like the output register
  always_ff @(posedge clk_i) begin
    shadow_q <= shadow_d;
  end

  // ---------------------------------------------------------------
  // Serial output
  // ---------------------------------------------------------------
  logic              sout_q;
  logic              sout_d;

  // In shift mode taken from the next shadow value so the pin moves with the shift itself; with mode high serial_in is passed through
  always_comb begin
    if (mode_s) begin
      sout_d = sin_s;
    end else begin
      sout_d = shadow_d[WORD_W-1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sout_q <= RST_SOUT;
    end else begin
      sout_q <= sout_d;
    end
  end

  assign serial_out_o = sout_q;

  // ---------------------------------------------------------------
  // Capture observation buffer
  // ---------------------------------------------------------------
  // Two entries: head is presented on the stream, tail holds the next one
  logic              push;
  logic              pop;
  logic [WORD_W-1:0] head_data_q;
  logic [WORD_W-1:0] head_data_d;
  logic              head_vld_q;
  logic              head_vld_d;
  logic [WORD_W-1:0] tail_data_q;
  logic [WORD_W-1:0] tail_data_d;
  logic              tail_vld_q;
  logic              tail_vld_d;
  logic              room_q;
  logic              room_d;
  logic              drop_q;
  logic              drop_d;

  // The controller cannot be stalled, so room is shown and an overrun is flagged
  assign push = (shop == SH_CAPTURE);
  assign pop  = head_vld_q & obs_ready_i;

  // A pop frees a slot in the same cycle, so a full buffer still takes a push
  always_comb begin
    head_data_d = head_data_q;
    head_vld_d  = head_vld_q;
    tail_data_d = tail_data_q;
    tail_vld_d  = tail_vld_q;
    drop_d      = 1'b0;
    if (pop) begin
      head_data_d = tail_data_q;
      head_vld_d  = tail_vld_q;
      tail_vld_d  = 1'b0;
    end
    if (push) begin
      if (!head_vld_d) begin
        head_data_d = shadow_d;
        head_vld_d  = 1'b1;
      end else if (!tail_vld_d) begin
        tail_data_d = shadow_d;
        tail_vld_d  = 1'b1;
      end else begin
        drop_d      = 1'b1;
      end
    end
    room_d = ~tail_vld_d;
  end

  // Valid bits reset; the data words need no reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      head_vld_q <= RST_VALID;
      tail_vld_q <= RST_VALID;
      room_q     <= 1'b1;
      drop_q     <= 1'b0;
    end else begin
      head_vld_q <= head_vld_d;
      tail_vld_q <= tail_vld_d;
      room_q     <= room_d;
      drop_q     <= drop_d;
    end
    head_data_q <= head_data_d;
    tail_data_q <= tail_data_d;
  end

  assign obs_data_o  = head_data_q;
  assign obs_valid_o = head_vld_q;
  assign obs_room_o  = room_q;
  assign obs_drop_o  = drop_q;

endmodule

// ===== bench/dgps_props.sv
// Pin-level checks for the shadow-scan ROM and its capture stream
`timescale 1ns/1ps
module dgps_props #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned WORD_W = 4
) (
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              reset_i,
  // Sequencer and scan pins
  input wire logic              main_clock_i,
  input wire logic [ADDR_W-1:0] word_select_i,
  input wire logic              mode_i,
  input wire logic              diag_clock_i,
  input wire logic              serial_in_i,
  input wire logic              serial_out_o,
  input wire logic              output_enable_n_i,
  input wire logic [WORD_W-1:0] data_out_o,
  input wire logic              data_out_oe_o,
  // Capture stream
  input wire logic [WORD_W-1:0] obs_data_o,
  input wire logic              obs_valid_o,
  input wire logic              obs_ready_i,
  input wire logic              obs_room_o,
  input wire logic              obs_drop_o
);
  logic       mc_q, dc_q, mo_q, ms_q;
  logic [2:0] age_q, mq_q, qq_q, dn_q;
  wire        m_rise = main_clock_i & ~mc_q;
  wire        d_rise = diag_clock_i & ~dc_q;

  function automatic logic [3:0] rom_f(logic [ADDR_W-1:0] a);
    return dgps_pkg::DEF_ROM_SEED ^ a[3:0] ^ a[7:4] ^ a[11:8];
  endfunction

  function automatic logic [2:0] sat(logic [2:0] x);
    return (x == 3'h7) ? x : x + 3'h1;
  endfunction

  // Cycles since release, last main rise, last diag rise or mode change;
  // saturating at 7 keeps them tiny while covering the 3-cycle pin latency
  always_ff @(posedge clk_i) begin
    mc_q <= main_clock_i;
    dc_q <= diag_clock_i;
    mo_q <= mode_i;
    if (reset_i) begin
      age_q <= 3'h0;
      mq_q <= 3'h0;
      qq_q <= 3'h0;
      dn_q <= 3'h0;
      ms_q <= 1'b0;
    end else begin
      age_q <= sat(age_q);
      mq_q <= m_rise ? 3'h0 : sat(mq_q);
      qq_q <= (d_rise | (mode_i ^ mo_q)) ? 3'h0 : sat(qq_q);
      if (d_rise && dn_q != 3'h4) dn_q <= dn_q + 3'h1;
      if (m_rise) ms_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  dout_load_a: assert property ($rose(main_clock_i) && !mode_i
    |-> ##[1:5] data_out_o == rom_f(word_select_i)) else $error("array word not loaded");
  dout_hold_a: assert property (ms_q && mq_q > 3'h4 |-> $stable(data_out_o))
    else $error("data_out moved without a main clock rise");
  sout_hold_a: assert property (dn_q == 3'h4 && !mode_i && qq_q > 3'h4
    |-> $stable(serial_out_o)) else $error("serial_out moved without a shift");
  sout_bypass_a: assert property ($stable(serial_in_i)[*4] ##0 (mode_i && qq_q > 3'h4)
    |-> serial_out_o == serial_in_i) else $error("serial_out not bypassed");
  oe_follow_a: assert property ($stable(output_enable_n_i)[*4] ##0 age_q > 3'h4
    |-> data_out_oe_o == !output_enable_n_i) else $error("driver enable wrong");
  reset_quiet_a: assert property ($fell(reset_i)
    |-> !data_out_oe_o && obs_room_o && !obs_valid_o) else $error("reset values wrong");
  capture_store_a: assert property ($rose(diag_clock_i) && mode_i && !serial_in_i &&
    obs_room_o |-> ##[1:5] obs_valid_o) else $error("capture not stored");
  noop_quiet_a: assert property ($rose(diag_clock_i) && mode_i && serial_in_i &&
    !obs_valid_o |=> !obs_valid_o [*5]) else $error("no-op produced a capture");
  obs_hold_a: assert property (obs_valid_o && !obs_ready_i
    |=> obs_valid_o && $stable(obs_data_o)) else $error("stalled word changed");
  drop_pulse_a: assert property (obs_drop_o |=> !obs_drop_o)
    else $error("drop flag longer than one cycle");

  cover property ($rose(diag_clock_i) && mode_i && !serial_in_i);
  cover property (obs_drop_o);
  cover property ($rose(main_clock_i) && $rose(diag_clock_i));
endmodule

bind dgps_top dgps_props #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) dgps_props_i (
  .clk_i(clk_i), .reset_i(reset_i), .main_clock_i(main_clock_i),
  .word_select_i(word_select_i), .mode_i(mode_i), .diag_clock_i(diag_clock_i),
  .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
  .output_enable_n_i(output_enable_n_i), .data_out_o(data_out_o),
  .data_out_oe_o(data_out_oe_o), .obs_data_o(obs_data_o), .obs_valid_o(obs_valid_o),
  .obs_ready_i(obs_ready_i), .obs_room_o(obs_room_o), .obs_drop_o(obs_drop_o)
);

// ===== bench/dgps_far.sv
// Sequencer and scan controller model driving the ROM control pins
`timescale 1ns/1ps
module dgps_far (
  // Clock
  input  wire logic        clk_i,
  // Pins towards the device
  output logic             main_clock_o,
  output logic             diag_clock_o,
  output logic             mode_o,
  output logic             serial_in_o,
  output logic [11:0]      word_select_o
);
  // Clocks stand low outside operations
  initial begin
    main_clock_o = 1'b0;
    diag_clock_o = 1'b0;
    mode_o = 1'b0;
    serial_in_o = 1'b0;
    word_select_o = 12'h000;
  end

  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One operation: 30 ns setup, 30 ns high, then low into the next call's setup,
  // so back-to-back shifts run at 65 ns, the nearest the 5 ns clock allows to 64;
  // a clock not asked for stays low, and mode, serial_in and word_select hold
  task automatic pulse(input logic m, input logic s, input logic [11:0] a,
                       input logic mc, input logic dc);
    mode_o <= m;
    serial_in_o <= s;
    word_select_o <= a;
    wait_n(6);
    main_clock_o <= mc;
    diag_clock_o <= dc;
    wait_n(6);
    main_clock_o <= 1'b0;
    diag_clock_o <= 1'b0;
    wait_n(1);
  endtask
endmodule

// ===== bench/testbench.sv
// Self-checking bench for the shadow-scan ROM
`timescale 1ns/1ps
module testbench;
  import dgps_pkg::*;
  logic        clk_i, reset_i, oen, ready, mck, dck, mode, sin;
  logic        sout, oe, valid, room, drop;
  logic [11:0] wsel;
  logic [3:0]  dout, obs, ext, bus;
  int          failures, cmp_count, drops;

  // External bus: the device wins while it drives, else the far side's levels
  assign bus = oe ? dout : ext;

  dgps_far dgps_far_i (.clk_i(clk_i), .main_clock_o(mck), .diag_clock_o(dck),
    .mode_o(mode), .serial_in_o(sin), .word_select_o(wsel));

  dgps_top dgps_top_i (.clk_i(clk_i), .reset_i(reset_i), .main_clock_i(mck),
    .word_select_i(wsel), .mode_i(mode), .diag_clock_i(dck), .serial_in_i(sin),
    .serial_out_o(sout), .output_enable_n_i(oen), .data_out_i(bus), .data_out_o(dout),
    .data_out_oe_o(oe), .obs_data_o(obs), .obs_valid_o(valid), .obs_ready_i(ready),
    .obs_room_o(room), .obs_drop_o(drop));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) if (drop === 1'b1) drops <= drops + 1;

  function automatic logic [3:0] rom(logic [11:0] a);
    return DEF_ROM_SEED ^ a[3:0] ^ a[7:4] ^ a[11:8];
  endfunction

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic p(input logic m, input logic s, input logic [11:0] a,
                   input logic mc, input logic dc);
    dgps_far_i.pulse(m, s, a, mc, dc);
  endtask

  // Shift four bits in, top bit first, so the shadow ends up equal to v
  task automatic shift_in(input logic [3:0] v);
    for (int i = 3; i >= 0; i--) p(1'b0, v[i], 12'h000, 1'b0, 1'b1);
  endtask

  // Settle in shift mode, then read the top bit before each shift
  task automatic shift_out(input logic [3:0] v);
    p(1'b0, 1'b0, 12'h000, 1'b0, 1'b0);
    for (int i = 3; i >= 0; i--) begin
      chk({3'h0, sout}, {3'h0, v[i]}, "serial_out bit");
      p(1'b0, 1'b0, 12'h000, 1'b0, 1'b1);
    end
  endtask

  task automatic pop();
    ready <= 1'b1;
    @(posedge clk_i);
    ready <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic t_load();
    logic [11:0] a [3] = '{12'h000, 12'hfff, 12'h5a3};
    foreach (a[i]) begin
      p(1'b0, 1'b0, a[i], 1'b1, 1'b0);
      chk(dout, rom(a[i]), "array word");
    end
    chk({3'h0, oe}, 4'h1, "drivers on");
    $display("load test done");
  endtask

  task automatic t_shadow();
    shift_in(4'hb);
    shift_out(4'hb);
    shift_in(4'h6);
    p(1'b1, 1'b0, 12'h000, 1'b1, 1'b0);
    chk(dout, 4'h6, "shadow to output");
    shift_out(4'h6);
    p(1'b1, 1'b1, 12'h000, 1'b0, 1'b0);
    chk({3'h0, sout}, 4'h1, "bypass high");
    p(1'b1, 1'b0, 12'h000, 1'b0, 1'b0);
    chk({3'h0, sout}, 4'h0, "bypass low");
    $display("shadow test done");
  endtask

  task automatic t_capture();
    p(1'b0, 1'b0, 12'h9c4, 1'b1, 1'b0);
    p(1'b1, 1'b0, 12'h000, 1'b0, 1'b1);
    chk(obs, rom(12'h9c4), "captured word");
    pop();
    p(1'b1, 1'b1, 12'h000, 1'b0, 1'b1);
    chk({3'h0, valid}, 4'h0, "no-op capture");
    shift_out(rom(12'h9c4));
    oen <= 1'b1;
    ext <= 4'ha;
    repeat (6) @(posedge clk_i);
    chk({3'h0, oe}, 4'h0, "drivers off");
    p(1'b1, 1'b0, 12'h000, 1'b0, 1'b1);
    chk(obs, 4'ha, "pin capture");
    pop();
    oen <= 1'b0;
    ext <= 4'h5;
    $display("capture test done");
  endtask

  task automatic t_both();
    p(1'b0, 1'b1, 12'h0f0, 1'b1, 1'b1);
    chk(dout, rom(12'h0f0), "load while shifting");
    shift_out(4'h5);
    $display("both clocks test done");
  endtask

  // Three different captured words into two entries with the reader stalled, then drain
  task automatic t_buf();
    logic [11:0] a [3] = '{12'h001, 12'h002, 12'h003};
    foreach (a[i]) begin
      p(1'b0, 1'b0, a[i], 1'b1, 1'b0);
      p(1'b1, 1'b0, 12'h000, 1'b0, 1'b1);
    end
    chk(drops[3:0], 4'h1, "one capture lost");
    chk({3'h0, room}, 4'h0, "no room left");
    chk(obs, rom(12'h001), "oldest word");
    pop();
    chk({3'h0, valid}, 4'h1, "second word");
    chk(obs, rom(12'h002), "second word data");
    pop();
    chk({3'h0, valid}, 4'h0, "drained");
    chk({3'h0, room}, 4'h1, "room again");
    $display("buffer test done");
  endtask

  task automatic tally_and_finish();
    $display("compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Guard against a hung run
  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    tally_and_finish();
  end

  initial begin
    reset_i = 1'b1;
    oen = 1'b0;
    ready = 1'b0;
    ext = 4'h5;
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_load();
    t_shadow();
    t_capture();
    t_both();
    t_buf();
    tally_and_finish();
  end
endmodule
